// ===== remote_port_pkg.sv
// Summary of operation
// - Attention high: bytes are interface commands.
// - Attention low: bytes are device messages.
// - One bus address 0..30, unique.
// - Talker until IFC, OTA, MLA, UNT.
// - Listener until IFC, MTA, UNL.
// - LLO locks front panel, GTL unlocks when addressed to listen.
// - DCL or addressed SDC flushes everything.
// - Device clear aborts running acquisition.
// - IFC unaddresses, stops bus, ends poll.
// - Serial characters are independent async frames.
// - Serial path carries no interface messages.
// - Three wires: XON/XOFF flow only.
// - Extended wiring: XON/XOFF or CTS/RTS.
// - Hardware mode: start a byte only while CTS high.
// - RTS high permits, low pauses controller.
// - DSR or DCD low stops within two bytes.
// - DTR asserted while powered.
// - Unconnected DCD, DSR, CTS read high.
// - Stop 17, resume 19; only flow codes sent while stopped.
// - 8N1 at 9600, 19200, 38400, 57600.
// - CTS low: no byte after current.
package remote_port_pkg;

	// ----------------------------------------
	// Clock and serial timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_BASE = 9600;
	localparam logic [1:0] BAUD_9600 = 2'h0;
	localparam logic [1:0] BAUD_19200 = 2'h1;
	localparam logic [1:0] BAUD_38400 = 2'h2;
	localparam logic [1:0] BAUD_57600 = 2'h3;
	localparam logic [3:0] DATA_BITS = 4'h8;

	// ----------------------------------------
	// Bus command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	localparam logic [7:0] CMD_UNL = 8'h3F;
	localparam logic [7:0] CMD_UNT = 8'h5F;
	localparam logic [2:0] GRP_LISTEN = 3'h1;
	localparam logic [2:0] GRP_TALK = 3'h2;
	localparam logic [4:0] ADDR_MAX = 5'h1E;

	// ----------------------------------------
	// Flow control
	// ----------------------------------------
	localparam logic [7:0] FLOW_STOP = 8'h11;
	localparam logic [7:0] FLOW_RESUME = 8'h13;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] LEVEL_HIGH = 4'h6;
	localparam logic [3:0] LEVEL_LOW = 4'h2;
	localparam logic [3:0] BUS_ROOM = 4'h6;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} txState_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_BITS = 3'b100
	} rxState_e;

	typedef struct packed {
		logic atn;
		logic ifc;
		logic valid;
		logic [7:0] data;
	} gpibIn_s;

	typedef struct packed {
		logic rxd;
		logic cts;
		logic dsr;
		logic dcd;
	} serialIn_s;

	typedef struct packed {
		logic txd;
		logic rts;
		logic dtr;
	} serialOut_s;

	function automatic int baud_div(input logic [1:0] sel);
		case (sel)
			BAUD_19200: baud_div = 2;
			BAUD_38400: baud_div = 4;
			BAUD_57600: baud_div = 6;
			default: baud_div = 1;
		endcase
	endfunction

endpackage

// ===== byte_fifo.sv
`timescale 1ns/1ns
module byte_fifo
	import remote_port_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic flush,
	// Filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] level
);

	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [LW-1:0] count;
		logic [WIDTH-1:0] head;
		logic full;
		logic empty;
	} fifo_s;

	fifo_s q, d;
	logic doWrite;
	logic doRead;

	always_comb begin
		d = q;
		doWrite = inValid && !q.full;
		doRead = outReady && !q.empty;
		if (doWrite) begin
			d.mem[q.wrPtr] = inData;
			d.wrPtr = (q.wrPtr == PW'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
		end
		if (doRead) begin
			d.rdPtr = (q.rdPtr == PW'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
		end
		if (doWrite && !doRead) begin
			d.count = q.count + 1'b1;
		end else if (doRead && !doWrite) begin
			d.count = q.count - 1'b1;
		end
		if (flush) begin
			d.wrPtr = '0;
			d.rdPtr = '0;
			d.count = '0;
		end
		// Head kept in a register so the output needs no read mux
		d.head = d.mem[d.rdPtr];
		d.full = (d.count == LW'(DEPTH));
		d.empty = (d.count == '0);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
			q.empty <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign inReady = !q.full;
	assign outValid = !q.empty;
	assign outData = q.head;
	assign level = q.count;

endmodule

// ===== instrument_remote_port_frontend.sv
`timescale 1ns/1ns
module instrument_remote_port_frontend
	import remote_port_pkg::*;
#(
	parameter int BIT_CYCLES_9600 = CLK_HZ / BAUD_BASE
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Configuration
	input wire logic [4:0] busAddr,
	input wire logic useSerial,
	input wire logic extendedWiring,
	input wire logic hwFlowSel,
	input wire logic [1:0] baudSel,
	input wire logic acqBusy,
	// Instrument bus byte in
	input wire gpibIn_s busIn,
	output logic busReady,
	// Instrument bus byte out
	output logic busOutValid,
	output logic [7:0] busOutData,
	input wire logic busOutTaken,
	// Serial pins
	input wire serialIn_s serIn,
	output serialOut_s serOut,
	// Messages toward the parser
	output logic msgValid,
	output logic [7:0] msgData,
	input wire logic msgReady,
	// Responses from the instrument
	input wire logic respValid,
	input wire logic [7:0] respData,
	output logic respReady,
	// Status and events
	output logic talker,
	output logic listener,
	output logic lockout,
	output logic serialPoll,
	output logic trigger,
	output logic parserReset,
	output logic abortAcq
);

	typedef struct packed {
		logic talker;
		logic listener;
		logic lockout;
		logic serialPoll;
		logic trigger;
		logic parserReset;
		logic abortAcq;
		logic busReady;
		logic busOutValid;
		logic [7:0] hold;
		logic holdValid;
		logic respReady;
		logic wrValid;
		logic [7:0] wrData;
		txState_e txState;
		logic [15:0] txCnt;
		logic [3:0] txBit;
		logic [9:0] txShift;
		logic txd;
		logic rts;
		logic dtr;
		logic xoffSent;
		logic remPaused;
		rxState_e rxState;
		logic [15:0] rxCnt;
		logic [3:0] rxBit;
		logic [7:0] rxShift;
	} port_s;

	port_s q, d;

	logic fifoInReady;
	logic [CNT_W-1:0] fifoLevel;
	logic fifoFlush;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] bit_cycles(input logic [1:0] sel);
		bit_cycles = 16'(BIT_CYCLES_9600 / baud_div(sel));
	endfunction

	function automatic logic is_mine(input logic [7:0] b,
			input logic [2:0] grp, input logic [4:0] addr);
		// Addresses above 30 are never matched
		is_mine = (b[7:5] == grp) && (b[4:0] == addr)
			&& (addr <= ADDR_MAX);
	endfunction

	logic swFlow;
	logic hwFlow;
	logic linkUp;
	logic mayStart;
	logic [7:0] busCmd;
	logic busCmdValid;
	logic clearNow;
	logic [15:0] fullBit;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// Three-wire wiring has no hardware lines to hand shake on
		hwFlow = extendedWiring && hwFlowSel;
		swFlow = !hwFlow;
		fullBit = bit_cycles(baudSel);
		// Pads pull these high, so an open line reads as ready
		linkUp = serIn.dsr && serIn.dcd;
		busCmd = busIn.data;
		busCmdValid = busIn.valid && busIn.atn && !useSerial;
		clearNow = 1'b0;
		d.trigger = 1'b0;
		d.parserReset = 1'b0;
		d.abortAcq = 1'b0;
		d.dtr = 1'b1;

		// Bus addressing and commands
		if (busCmdValid) begin
			if (is_mine(busCmd, GRP_TALK, busAddr)) begin
				d.talker = 1'b1;
				d.listener = 1'b0;
			end else if (busCmd[7:5] == GRP_TALK) begin
				d.talker = 1'b0;
			end
			if (is_mine(busCmd, GRP_LISTEN, busAddr)) begin
				d.listener = 1'b1;
				d.talker = 1'b0;
			end
			if (busCmd == CMD_UNL) begin
				d.listener = 1'b0;
			end
			if (busCmd == CMD_LLO) begin
				d.lockout = 1'b1;
			end
			if (busCmd == CMD_GTL && q.listener) begin
				d.lockout = 1'b0;
			end
			if (busCmd == CMD_SPE) begin
				d.serialPoll = 1'b1;
			end
			if (busCmd == CMD_SPD) begin
				d.serialPoll = 1'b0;
			end
			if (busCmd == CMD_GET && q.listener) begin
				d.trigger = 1'b1;
			end
			if (busCmd == CMD_DCL
					|| (busCmd == CMD_SDC && q.listener)) begin
				clearNow = 1'b1;
			end
		end

		// Data bytes from the controller into the input buffer
		if (q.wrValid && fifoInReady) begin
			d.wrValid = 1'b0;
		end
		if (busIn.valid && !busIn.atn && q.listener && !useSerial) begin
			d.wrValid = 1'b1;
			d.wrData = busIn.data;
		end

		// Response holding register shared by both ports
		if (respValid && q.respReady) begin
			d.hold = respData;
			d.holdValid = 1'b1;
		end
		if (q.busOutValid && busOutTaken) begin
			d.holdValid = 1'b0;
		end

		// ----------------------------------------
		// Serial receiver
		// ----------------------------------------
		unique case (q.rxState)
			RX_IDLE: begin
				if (!serIn.rxd) begin
					d.rxState = RX_START;
					// Loads one less, as the zero count is a cycle too
					d.rxCnt = (fullBit >> 1) - 1'b1;
				end
			end
			RX_START: begin
				if (q.rxCnt != '0) begin
					d.rxCnt = q.rxCnt - 1'b1;
				end else if (!serIn.rxd) begin
					d.rxState = RX_BITS;
					d.rxCnt = fullBit - 1'b1;
					d.rxBit = '0;
				end else begin
					d.rxState = RX_IDLE;
				end
			end
			RX_BITS: begin
				if (q.rxCnt != '0) begin
					d.rxCnt = q.rxCnt - 1'b1;
				end else if (q.rxBit != DATA_BITS) begin
					d.rxShift = {serIn.rxd, q.rxShift[7:1]};
					d.rxBit = q.rxBit + 1'b1;
					d.rxCnt = fullBit - 1'b1;
				end else begin
					// Stop bit; a framing error drops the character
					d.rxState = RX_IDLE;
					if (serIn.rxd && useSerial) begin
						if (swFlow && q.rxShift == FLOW_STOP) begin
							d.remPaused = 1'b1;
						end else if (swFlow && q.rxShift == FLOW_RESUME) begin
							d.remPaused = 1'b0;
						end else begin
							// No interface messages exist on this path
							d.wrValid = 1'b1;
							d.wrData = q.rxShift;
						end
					end
				end
			end
		endcase

		// ----------------------------------------
		// Serial transmitter
		// ----------------------------------------
		mayStart = linkUp && (!hwFlow || serIn.cts);
		unique case (q.txState)
			TX_IDLE: begin
				d.txd = 1'b1;
				if (useSerial && mayStart) begin
					if (swFlow && !q.xoffSent && fifoLevel >= LEVEL_HIGH) begin
						d.txShift = {1'b1, FLOW_STOP, 1'b0};
						d.xoffSent = 1'b1;
						d.txState = TX_SEND;
					end else if (q.xoffSent
							&& (hwFlow || fifoLevel <= LEVEL_LOW)) begin
						d.txShift = {1'b1, FLOW_RESUME, 1'b0};
						d.xoffSent = 1'b0;
						d.txState = TX_SEND;
					end else if (q.holdValid
							&& !(swFlow && q.remPaused)) begin
						d.txShift = {1'b1, q.hold, 1'b0};
						d.holdValid = 1'b0;
						d.txState = TX_SEND;
					end
					d.txBit = '0;
					d.txCnt = '0;
				end
			end
			TX_SEND: begin
				// The byte under way always completes its frame
				d.txd = q.txShift[0];
				if (q.txCnt != fullBit - 1'b1) begin
					d.txCnt = q.txCnt + 1'b1;
				end else begin
					d.txCnt = '0;
					d.txShift = {1'b1, q.txShift[9:1]};
					d.txBit = q.txBit + 1'b1;
					if (q.txBit == DATA_BITS + 1'b1) begin
						d.txState = TX_IDLE;
						d.txd = 1'b1;
					end
				end
			end
		endcase

		// Receive-side pause in hardware mode
		d.rts = hwFlow ? (fifoLevel < LEVEL_HIGH) : 1'b1;

		// ----------------------------------------
		// Device clear and interface clear
		// ----------------------------------------
		if (clearNow) begin
			d.wrValid = 1'b0;
			d.holdValid = 1'b0;
			d.parserReset = 1'b1;
			d.abortAcq = acqBusy;
		end
		if (busIn.ifc && !useSerial) begin
			d.talker = 1'b0;
			d.listener = 1'b0;
			d.serialPoll = 1'b0;
			d.wrValid = 1'b0;
		end

		// Talker output, only in data mode
		d.busOutValid = !useSerial && d.talker && !busIn.atn
			&& !busIn.ifc && d.holdValid;
		d.respReady = !d.holdValid && !(respValid && q.respReady);
		// Margin covers a byte already in flight to the buffer
		d.busReady = !useSerial && d.listener && !d.wrValid
			&& !busIn.ifc && fifoLevel < BUS_ROOM;
	end

	assign fifoFlush = clearNow;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
			q.txState <= TX_IDLE;
			q.rxState <= RX_IDLE;
			q.txd <= 1'b1;
			q.rts <= 1'b1;
			q.dtr <= 1'b1;
			q.respReady <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Input buffer toward the parser
	// ----------------------------------------
	// Only eight deep, so a controller using the full 32-byte
	// overrun after a stop code can still overflow it
	byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) inputBuffer (
		.clk(clk),
		.reset_n(reset_n),
		.flush(fifoFlush),
		.inValid(q.wrValid),
		.inData(q.wrData),
		.inReady(fifoInReady),
		.outValid(msgValid),
		.outData(msgData),
		.outReady(msgReady),
		.level(fifoLevel)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign busReady = q.busReady;
	assign busOutValid = q.busOutValid;
	assign busOutData = q.hold;
	assign respReady = q.respReady;
	assign serOut = {q.txd, q.rts, q.dtr};
	assign talker = q.talker;
	assign listener = q.listener;
	assign lockout = q.lockout;
	assign serialPoll = q.serialPoll;
	assign trigger = q.trigger;
	assign parserReset = q.parserReset;
	assign abortAcq = q.abortAcq;

endmodule

// ===== remote_port_monitor.sv
`timescale 1ns/1ns
module remote_port_monitor
	import remote_port_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic [4:0] busAddr,
	input wire logic useSerial,
	input wire logic acqBusy,
	input wire gpibIn_s busIn,
	input wire serialOut_s serOut,
	input wire logic talker,
	input wire logic listener,
	input wire logic lockout,
	input wire logic serialPoll,
	input wire logic parserReset,
	input wire logic abortAcq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ----
	// Command decode
	// ----
	// IFC in the same cycle would outrank any address
	logic cmd;
	logic own;
	assign cmd = busIn.valid && busIn.atn && !busIn.ifc && !useSerial;
	assign own = busAddr <= ADDR_MAX;

	AST_DTR: assert property (serOut.dtr)
		else $error("dtr dropped");
	AST_MLA: assert property (cmd && own &&
		busIn.data == {GRP_LISTEN, busAddr} |=> listener && !talker)
		else $error("listen address missed");
	AST_MTA: assert property (cmd && own &&
		busIn.data == {GRP_TALK, busAddr} |=> talker && !listener)
		else $error("talk address missed");
	AST_UNL: assert property (cmd && busIn.data == CMD_UNL
		|=> !listener)
		else $error("unlisten ignored");
	AST_UNT: assert property (cmd && busIn.data == CMD_UNT
		|=> !talker)
		else $error("untalk ignored");
	AST_IFC: assert property (busIn.ifc && !useSerial
		|=> !talker && !listener && !serialPoll)
		else $error("interface clear ignored");
	AST_LLO: assert property (cmd && busIn.data == CMD_LLO
		|=> lockout)
		else $error("lockout not set");
	AST_DCL: assert property (cmd && busIn.data == CMD_DCL
		|=> parserReset && abortAcq == $past(acqBusy))
		else $error("device clear not acted on");
	AST_SER: assert property (useSerial && busIn.valid &&
		busIn.atn |=> !parserReset)
		else $error("bus command acted on in serial mode");
endmodule

// ===== controller_model.sv
`timescale 1ns/1ns
module controller_model
	import remote_port_pkg::*;
#(
	parameter int BIT = 2
) (
	// Clock
	input wire logic clk,
	// Serial pins
	input wire serialOut_s serOut,
	output serialIn_s serIn,
	// Decoded characters
	output logic gotValid,
	output logic [7:0] gotData
);
	// Bit length in cycles; changed only while the line is idle
	int bitLen = BIT;

	initial begin
		serIn = 4'hF;
		gotValid = 1'b0;
		gotData = 8'h00;
	end

	task automatic setCts(input logic c);
		@(negedge clk);
		serIn.cts = c;
	endtask

	task automatic setDsr(input logic c);
		@(negedge clk);
		serIn.dsr = c;
	endtask

	// Few bytes ever follow a stop code, well under the allowance
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		int n;
		f = {1'b1, b, 1'b0};
		n = 0;
		while (!serOut.rts && n < 5000) begin
			@(negedge clk);
			n++;
		end
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			serIn.rxd = f[i];
			repeat (bitLen - 1) @(negedge clk);
		end
	endtask

	// Samples mid-bit, so one cycle of skew is harmless
	always begin
		@(negedge serOut.txd);
		repeat (bitLen / 2) @(negedge clk);
		for (int k = 0; k < 8; k++) begin
			repeat (bitLen) @(negedge clk);
			gotData[k] = serOut.txd;
		end
		repeat (bitLen) @(negedge clk);
		gotValid = serOut.txd;
		@(negedge clk);
		gotValid = 1'b0;
	end
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
	numChecks++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end
module testbench
	import remote_port_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] busAddr = 5'h00;
	logic useSerial = 1'b0;
	logic extendedWiring = 1'b0;
	logic hwFlowSel = 1'b0;
	logic [1:0] baudSel = 2'h3;
	logic acqBusy = 1'b0;
	gpibIn_s busIn = '0;
	logic busOutTaken = 1'b0;
	logic msgReady = 1'b1;
	logic respValid = 1'b0;
	logic [7:0] respData = 8'h00;
	logic busReady, busOutValid, msgValid, respReady, gotValid;
	logic talker, listener, lockout, serialPoll, trigger;
	logic [7:0] busOutData, msgData, gotData, msgExp, txExp;
	serialIn_s serIn;
	serialOut_s serOut;
	logic [7:0] msgQ[$];
	logic [7:0] txQ[$];
	logic [7:0] seed = 8'h5F;
	int errors = 0;
	int numChecks = 0;
	int n;

	always #5 clk = ~clk;

	instrument_remote_port_frontend #(.BIT_CYCLES_9600(12))
		u_instrument_remote_port_frontend (.clk, .reset_n, .busAddr,
		.useSerial, .extendedWiring, .hwFlowSel, .baudSel, .acqBusy,
		.busIn, .busReady, .busOutValid, .busOutData, .busOutTaken,
		.serIn, .serOut, .msgValid, .msgData, .msgReady, .respValid,
		.respData, .respReady, .talker, .listener, .lockout,
		.serialPoll, .trigger, .parserReset(), .abortAcq());
	controller_model #(.BIT(2)) u_controller_model (.clk, .serOut,
		.serIn, .gotValid, .gotData);

	// ----
	// Helpers
	// ----
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic cmd(input logic [7:0] d);
		@(negedge clk);
		busIn = {1'b1, 1'b0, 1'b1, d};
		@(negedge clk);
		// Back to data mode, or talker bytes stay hidden
		busIn = '0;
	endtask

	// Offers only while the port has room, so nothing is lost
	task automatic dat(input logic keep);
		seed = lfsr(seed);
		if (keep) msgQ.push_back(seed);
		do @(negedge clk); while (!busReady);
		busIn = {1'b0, 1'b0, 1'b1, seed};
		@(negedge clk);
		busIn.valid = 1'b0;
	endtask

	task automatic ser();
		seed = lfsr(seed) | 8'h80;
		msgQ.push_back(seed);
		u_controller_model.send(seed);
	endtask

	task automatic resp(input logic [7:0] b);
		@(negedge clk);
		respValid = 1'b1;
		respData = b;
		do @(posedge clk); while (!respReady);
		@(negedge clk);
		respValid = 1'b0;
	endtask

	task automatic quiet();
		repeat (40) begin
			@(negedge clk);
			`CHK("txdHeld", 1'b1, serOut.txd)
		end
	endtask

	task automatic drain();
		n = 0;
		while ((msgQ.size() || txQ.size()) && n < 2000) begin
			@(negedge clk);
			n++;
		end
		`CHK("drained", 1'b1, n < 2000)
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----
	// Result watchers
	// ----
	always @(posedge clk) begin
		if (reset_n && msgValid && msgReady) begin
			msgExp = msgQ.size() ? msgQ.pop_front() : 8'hXX;
			`CHK("msgData", msgExp, msgData)
		end
		if (gotValid) begin
			txExp = txQ.size() ? txQ.pop_front() : 8'hXX;
			`CHK("txChar", txExp, gotData)
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		`CHK("idle", 6'h0F, {talker, listener, respReady, serOut})
		$display("reset test done");
		busAddr = 5'(seed % 8'h1F);
		cmd({GRP_LISTEN, busAddr});
		`CHK("listener", 1'b1, listener)
		repeat (3) dat(1'b1);
		cmd(CMD_LLO);
		`CHK("lockout", 1'b1, lockout)
		cmd(CMD_GTL);
		`CHK("lockout", 1'b0, lockout)
		cmd(CMD_GET);
		`CHK("trigger", 1'b1, trigger)
		cmd({GRP_TALK, busAddr});
		`CHK("talkState", 2'h2, {talker, listener})
		seed = lfsr(seed);
		resp(seed);
		do @(negedge clk); while (!busOutValid);
		`CHK("busOutData", seed, busOutData)
		busOutTaken = 1'b1;
		@(negedge clk);
		busOutTaken = 1'b0;
		cmd({GRP_LISTEN, busAddr});
		`CHK("talkState", 2'h1, {talker, listener})
		cmd(CMD_UNL);
		`CHK("unlisten", 1'b0, listener)
		cmd({GRP_TALK, busAddr});
		cmd(CMD_UNT);
		`CHK("untalk", 2'h0, {talker, listener})
		cmd({GRP_LISTEN, busAddr});
		$display("addressing test done");
		msgReady = 1'b0;
		acqBusy = 1'b1;
		dat(1'b0);
		repeat (3) @(negedge clk);
		cmd(CMD_DCL);
		`CHK("flushed", 1'b0, msgValid)
		msgReady = 1'b1;
		acqBusy = 1'b0;
		cmd(CMD_SPE);
		`CHK("pollOn", 1'b1, serialPoll)
		@(negedge clk);
		busIn.ifc = 1'b1;
		@(negedge clk);
		busIn.ifc = 1'b0;
		`CHK("ifc", 3'h0, {talker, listener, serialPoll})
		$display("clear test done");
		useSerial = 1'b1;
		cmd(CMD_DCL);
		repeat (2) ser();
		u_controller_model.send(FLOW_STOP);
		seed = lfsr(seed);
		txQ.push_back(seed);
		resp(seed);
		quiet();
		u_controller_model.send(FLOW_RESUME);
		drain();
		$display("software flow test done");
		extendedWiring = 1'b1;
		hwFlowSel = 1'b1;
		msgReady = 1'b0;
		repeat (6) ser();
		repeat (4) @(negedge clk);
		`CHK("rtsPause", 1'b0, serOut.rts)
		msgReady = 1'b1;
		drain();
		`CHK("rtsGo", 1'b1, serOut.rts)
		u_controller_model.setCts(1'b0);
		seed = lfsr(seed);
		txQ.push_back(seed);
		resp(seed);
		quiet();
		u_controller_model.setCts(1'b1);
		drain();
		u_controller_model.setDsr(1'b0);
		seed = lfsr(seed);
		txQ.push_back(seed);
		resp(seed);
		quiet();
		u_controller_model.setDsr(1'b1);
		drain();
		$display("hardware flow test done");
		baudSel = BAUD_9600;
		u_controller_model.bitLen = 12;
		repeat (2) ser();
		seed = lfsr(seed);
		txQ.push_back(seed);
		resp(seed);
		drain();
		$display("slow rate test done");
		end_of_test();
	end
endmodule
bind instrument_remote_port_frontend remote_port_monitor
	u_remote_port_monitor (.clk, .reset_n, .busAddr, .useSerial,
	.acqBusy, .busIn, .serOut, .talker, .listener, .lockout,
	.serialPoll, .parserReset, .abortAcq);
